/* File: core/imc_top.sv */
// Interrupt mailbox and privileged channel access block
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module imc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Accelerator mailbox write channel
    input wire logic mbox_wr_valid,
    input wire logic [31:0] mbox_wr_data,
    output logic mbox_wr_ready,
    // Accelerator channel state
    input wire logic [11:0] event_status,
    input wire logic [31:0] list_stall_status,
    output logic [11:0] event_mask,
    // Interrupt
    output logic irq
);

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------

    // Mailbox, select, isolation and event mask state in one record
    typedef struct packed {
        logic count;              // Mailbox channel count, 1 = free
        logic [31:0] word;        // Single mailbox entry
        logic [4:0] sel;          // Channel select
        logic iso;                // Isolation mode
        logic [11:0] evt_mask;    // Event mask channel
        logic pop_arm;            // Read caught at setup may free slot
    } imc_state_s;

    imc_state_s st_ff;
    imc_state_s nxt_st;

    imc_pkg::imc_req_s req;       // Decoded bus request
    logic [31:0] rdata;           // Read mux into the slave
    logic dec_err;                // Unmapped address
    logic [4:0] eff_sel;          // Select after isolation override
    logic acc_ok;                 // Selected channel reachable
    logic wr_take;                // Accelerator write accepted
    logic wr_block;               // Accelerator write refused
    logic host_pop;               // Host read frees slot
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] ev_set;
    logic [1:0] hw_clr;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------

    // Channels reachable through count and data ports
    function automatic logic reachable(input logic [4:0] ch);
        reachable = (ch == imc_pkg::CH_EVT_STAT) ||
                    (ch == imc_pkg::CH_EVT_MASK) ||
                    (ch == imc_pkg::CH_LIST) ||
                    (ch == imc_pkg::CH_INTR_MBOX);
    endfunction

    // Address is in the map
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == imc_pkg::OFS_MBOX) || (a == imc_pkg::OFS_SEL) ||
                 (a == imc_pkg::OFS_CNT) || (a == imc_pkg::OFS_DATA) ||
                 (a == imc_pkg::OFS_STAT) || (a == imc_pkg::OFS_MASK) ||
                 (a == imc_pkg::OFS_CTRL) || (a == imc_pkg::OFS_INFO);
    endfunction

    //------------------------------------------------------------
    // Bus front end
    //------------------------------------------------------------

    imc_apb_slave u_slave (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .req(req),
        .rdata(rdata),
        .err(dec_err)
    );

    // Unmapped places answer with an error and read as zero
    assign dec_err = ~mapped(req.addr);

    //------------------------------------------------------------
    // Channel steering
    //------------------------------------------------------------

    // Isolation pins the select to the decrementer channel
    assign eff_sel = st_ff.iso ? imc_pkg::CH_DECR : st_ff.sel;
    assign acc_ok = reachable(eff_sel);

    // Mailbox handshake: no room means stall, never overwrite
    // Ready is the count flop itself, so it never glitches
    assign mbox_wr_ready = st_ff.count;
    assign wr_take = mbox_wr_valid & st_ff.count;
    assign wr_block = mbox_wr_valid & ~st_ff.count;

    // Only a read that saw a full slot at setup frees it
    assign host_pop = req.rd & (req.addr == imc_pkg::OFS_MBOX) & st_ff.pop_arm;

    //------------------------------------------------------------
    // Read mux
    //------------------------------------------------------------

    // Read data per address, sampled at setup by the slave
    always_comb begin
        rdata = 32'h0000_0000;
        case (req.addr)
            imc_pkg::OFS_MBOX: begin
                rdata = st_ff.word;
            end
            imc_pkg::OFS_SEL: begin
                rdata = {27'h000_0000, eff_sel};
            end
            imc_pkg::OFS_CNT: begin
                // Unreachable channels read as zero
                if (acc_ok) begin
                    rdata = 32'h0000_0001;
                    if (eff_sel == imc_pkg::CH_INTR_MBOX) begin
                        rdata = {31'h0000_0000, st_ff.count};
                    end
                end
            end
            imc_pkg::OFS_DATA: begin
                if (acc_ok) begin
                    case (eff_sel)
                        imc_pkg::CH_EVT_STAT: begin
                            rdata = {20'h0_0000, event_status};
                        end
                        imc_pkg::CH_EVT_MASK: begin
                            rdata = {20'h0_0000, st_ff.evt_mask};
                        end
                        imc_pkg::CH_LIST: begin
                            rdata = list_stall_status;
                        end
                        imc_pkg::CH_INTR_MBOX: begin
                            rdata = st_ff.word;
                        end
                        default: begin
                            rdata = 32'h0000_0000;
                        end
                    endcase
                end
            end
            imc_pkg::OFS_STAT: begin
                rdata = {30'h0000_0000, irq_stat};
            end
            imc_pkg::OFS_MASK: begin
                rdata = {30'h0000_0000, irq_mask};
            end
            imc_pkg::OFS_CTRL: begin
                rdata = {31'h0000_0000, st_ff.iso};
            end
            imc_pkg::OFS_INFO: begin
                rdata = {30'h0000_0000, irq, st_ff.count};
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------

    always_comb begin
        nxt_st = st_ff;
        // Arm the pop only when the slot was full at setup
        if (req.setup) begin
            nxt_st.pop_arm = ~st_ff.count;
        end
        // Accelerator fills the single slot
        if (wr_take) begin
            nxt_st.word = mbox_wr_data;
            nxt_st.count = 1'b0;
        end
        // Host read frees the slot; extra reads change nothing
        if (host_pop) begin
            nxt_st.count = 1'b1;
        end
        // Register writes
        if (req.wr) begin
            case (req.addr)
                imc_pkg::OFS_SEL: begin
                    if (!st_ff.iso) begin
                        nxt_st.sel = req.wdata[4:0];
                    end
                end
                imc_pkg::OFS_DATA: begin
                    // Only the defined bits land, rest dropped
                    if (acc_ok && eff_sel == imc_pkg::CH_EVT_MASK) begin
                        nxt_st.evt_mask = req.wdata[11:0];
                    end
                end
                imc_pkg::OFS_CTRL: begin
                    nxt_st.iso = req.wdata[imc_pkg::CTRL_ISO_BIT];
                    // A word landing this cycle keeps the slot full
                    if (req.wdata[imc_pkg::CTRL_REINIT_BIT] && !wr_take) begin
                        nxt_st.count = 1'b1;
                    end
                end
                default: begin
                    nxt_st.count = nxt_st.count;
                end
            endcase
        end
    end

    // State register; count comes up free
    // Word resets to zero so an early read is defined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.count <= imc_pkg::RST_COUNT;
            st_ff.word <= imc_pkg::RST_WORD;
            st_ff.sel <= imc_pkg::RST_SEL;
            st_ff.iso <= 1'b0;
            st_ff.evt_mask <= 12'h000;
            st_ff.pop_arm <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign event_mask = st_ff.evt_mask;

    //------------------------------------------------------------
    // Interrupts
    //------------------------------------------------------------

    // Mailbox bit follows the count edges; stall bit is sticky
    always_comb begin
        ev_set = 2'b00;
        hw_clr = 2'b00;
        ev_set[imc_pkg::IRQ_MBOX_BIT] = wr_take;
        ev_set[imc_pkg::IRQ_STALL_BIT] = wr_block;
        hw_clr[imc_pkg::IRQ_MBOX_BIT] = ~st_ff.count & nxt_st.count;
    end

    // Status and mask live in the interrupt helper
    imc_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ev_set(ev_set),
        .hw_clr(hw_clr),
        .stat_we(req.wr && req.addr == imc_pkg::OFS_STAT),
        .mask_we(req.wr && req.addr == imc_pkg::OFS_MASK),
        .wdata(req.wdata[1:0]),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(irq)
    );

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Mailbox slot and count
    AST_WR_DROP: assert property (wr_take |=> !st_ff.count && !mbox_wr_ready)
        else $error("Count did not drop after mailbox write");

    AST_WR_WORD: assert property (wr_take |=> st_ff.word == $past(mbox_wr_data))
        else $error("Mailbox word not stored");

    AST_POP: assert property (host_pop && !wr_take |=> st_ff.count)
        else $error("Host read did not free slot");

    AST_READ_HOLD: assert property (req.rd && req.addr == imc_pkg::OFS_MBOX && st_ff.count
        && !mbox_wr_valid |=> st_ff.count && $stable(st_ff.word))
        else $error("Read at count one changed mailbox");

    AST_MBOX_RD: assert property (req.setup && !pwrite && req.addr == imc_pkg::OFS_MBOX
        |=> prdata == $past(st_ff.word))
        else $error("Mailbox read data wrong");

    AST_STALL: assert property (!st_ff.count && mbox_wr_valid && !host_pop
        |=> $stable(st_ff.word))
        else $error("Full mailbox overwritten");

    AST_REINIT: assert property (req.wr && req.addr == imc_pkg::OFS_CTRL && !wr_take
        && req.wdata[imc_pkg::CTRL_REINIT_BIT] |=> st_ff.count)
        else $error("Reinit did not free slot");

    // Interrupt status
    AST_IRQ_RISE: assert property (wr_take |=> irq_stat[0])
        else $error("Mailbox interrupt not raised");

    AST_IRQ_FALL: assert property ($rose(st_ff.count) |-> !irq_stat[0])
        else $error("Mailbox interrupt not lowered");

    AST_IRQ_MASK: assert property (irq_stat[0] && !irq_mask[0] && !irq_stat[1] |-> !irq)
        else $error("Masked interrupt delivered");

    AST_STALL_FLAG: assert property (wr_block |=> irq_stat[imc_pkg::IRQ_STALL_BIT])
        else $error("Stall not flagged");

    // Channel access
    AST_ISO_SEL: assert property (st_ff.iso && req.wr && req.addr == imc_pkg::OFS_SEL
        |=> $stable(st_ff.sel) && eff_sel == imc_pkg::CH_DECR)
        else $error("Isolation did not pin select");

    AST_ZERO_RD: assert property (req.setup && !pwrite && !acc_ok
        && req.addr == imc_pkg::OFS_DATA |=> prdata == 32'h0000_0000)
        else $error("Unreachable channel read nonzero");

    AST_NARROW: assert property (req.wr && req.addr == imc_pkg::OFS_DATA && acc_ok
        && eff_sel == imc_pkg::CH_EVT_MASK |=> event_mask == $past(req.wdata[11:0]))
        else $error("Event mask write wrong");

    AST_DROP_WR: assert property (req.wr && req.addr == imc_pkg::OFS_DATA && !acc_ok
        |=> $stable(st_ff.evt_mask))
        else $error("Unreachable channel written");

    // Scenario coverage
    COV_FILL: cover property (wr_take ##[1:20] host_pop);
    COV_STALL: cover property (wr_block ##1 wr_block);
    COV_ISO: cover property (st_ff.iso && req.wr && req.addr == imc_pkg::OFS_SEL);
    COV_IRQ: cover property ($rose(irq));
    COV_REINIT: cover property (req.wr && req.addr == imc_pkg::OFS_CTRL && !st_ff.count);

endmodule

/* File: core/imc_pkg.sv */
// Package: constants, register map and carriers for the interrupt mailbox block
//----------------------------------------------------------------
//----------------------------------------------------------------
package imc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_MBOX = 8'h00;   // outbound_interrupt_mailbox_reg
    localparam logic [7:0] OFS_SEL = 8'h04;    // channel_select_reg
    localparam logic [7:0] OFS_CNT = 8'h08;    // channel count
    localparam logic [7:0] OFS_DATA = 8'h0C;   // channel_data_port
    localparam logic [7:0] OFS_STAT = 8'h10;   // interrupt status, write one to clear
    localparam logic [7:0] OFS_MASK = 8'h14;   // class2_interrupt_mask
    localparam logic [7:0] OFS_CTRL = 8'h18;   // isolation and count reinit
    localparam logic [7:0] OFS_INFO = 8'h1C;   // live mailbox state

    // Field positions
    localparam int CTRL_ISO_BIT = 0;           // Isolation mode
    localparam int CTRL_REINIT_BIT = 1;        // Write one: count back to 1
    localparam int IRQ_MBOX_BIT = 0;           // Mailbox interrupt
    localparam int IRQ_STALL_BIT = 1;          // Write attempted while full
    localparam int IRQ_W = 2;
    localparam int EVT_W = 12;                 // Event mask and status width

    // Channel numbers
    localparam logic [4:0] CH_EVT_STAT = 5'h00; // event_status_read_channel
    localparam logic [4:0] CH_EVT_MASK = 5'h01; // event_mask_write_channel
    localparam logic [4:0] CH_DECR = 5'h07;     // decrementer_write_channel
    localparam logic [4:0] CH_LIST = 5'h19;     // list_stall_status_channel
    localparam logic [4:0] CH_INTR_MBOX = 5'h1E; // interrupt_mailbox_write_channel

    // Reset values
    localparam logic RST_COUNT = 1'b1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [4:0] RST_SEL = 5'h00;

    // Decoded bus request
    typedef struct packed {
        logic setup;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } imc_req_s;

endpackage

/* File: core/imc_apb_slave.sv */
// APB slave front end: decodes phases and registers read data
`timescale 1ns/1ps
module imc_apb_slave (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block side
    output imc_pkg::imc_req_s req,
    input wire logic [31:0] rdata,
    input wire logic err
);
    // Read data is caught at setup so the bus sees a flop
    typedef struct packed {
        logic [31:0] prdata;
    } imc_slv_s;

    imc_slv_s st_ff;
    imc_slv_s nxt_st;

    // Phase decode
    always_comb begin
        req.setup = psel & ~penable;
        req.wr = psel & penable & pwrite;
        req.rd = psel & penable & ~pwrite;
        req.addr = paddr;
        req.wdata = pwdata;
    end

    // No wait states: setup, then a ready access
    assign pready = psel & penable;
    assign pslverr = pready & err;
    assign prdata = st_ff.prdata;

    // Next read data
    always_comb begin
        nxt_st = st_ff;
        if (req.setup && !pwrite) begin
            nxt_st.prdata = rdata;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

/* File: core/imc_irq.sv */
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
module imc_irq (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events
    input wire logic [1:0] ev_set,
    input wire logic [1:0] hw_clr,
    // Software access
    input wire logic stat_we,
    input wire logic mask_we,
    input wire logic [1:0] wdata,
    // Results
    output logic [1:0] stat,
    output logic [1:0] mask,
    output logic irq
);
    typedef struct packed {
        logic [1:0] stat;
        logic [1:0] mask;
    } imc_irq_s;

    imc_irq_s st_ff;
    imc_irq_s nxt_st;

    // Clears first, then sets, so a same-cycle event wins
    always_comb begin
        nxt_st = st_ff;
        if (stat_we) begin
            nxt_st.stat = nxt_st.stat & ~wdata;
        end
        nxt_st.stat = (nxt_st.stat & ~hw_clr) | ev_set;
        if (mask_we) begin
            nxt_st.mask = wdata;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stat = st_ff.stat;
    assign mask = st_ff.mask;
    assign irq = |(st_ff.stat & st_ff.mask);
endmodule

/* File: verification/imc_host_model.sv */
// Host core model: APB master that reaches the mailbox and channel registers
`timescale 1ns/1ps
module imc_host_model (
    // Clock
    input wire logic pclk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int waits; // Wait cycles seen by the last transfer
    //----------------------------------------------------------------
    // Idle bus
    //----------------------------------------------------------------
    // Bus starts idle; address and data hold a junk pattern
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hA5;
        pwdata = 32'h5A5A_5A5A;
    end

    //----------------------------------------------------------------
    // One transfer: setup, access until pready, release
    //----------------------------------------------------------------
    // Every word is a whole 32-bit access; a mailbox read frees a full slot
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Bounded wait so a dead slave cannot hang the host
        while (pready !== 1'b1 && n < 64) begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        waits = n;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep showing the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* File: verification/spe_interrupt_mailbox_channel_access_tb.sv */
// Testbench: random and corner-case checks of the interrupt mailbox block
`timescale 1ns/1ps
module spe_interrupt_mailbox_channel_access_tb;
    //----------------------------------------------------------------
    // Signals
    //----------------------------------------------------------------
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mbox_wr_valid;
    logic [31:0] mbox_wr_data;
    logic mbox_wr_ready;
    logic [11:0] event_status;
    logic [31:0] list_stall_status;
    logic [11:0] event_mask;
    logic irq;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [31:0] rdv;
    logic erv;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] wd;
    logic [11:0] mexp;
    logic [4:0] c;
    // Channels visited: reachable ones, the decrementer and an unused one
    logic [4:0] tbl [6] = '{imc_pkg::CH_EVT_STAT, imc_pkg::CH_EVT_MASK, imc_pkg::CH_LIST,
                            imc_pkg::CH_INTR_MBOX, imc_pkg::CH_DECR, 5'h03};

    //----------------------------------------------------------------
    // Instances
    //----------------------------------------------------------------
    imc_top imc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mbox_wr_valid(mbox_wr_valid), .mbox_wr_data(mbox_wr_data), .mbox_wr_ready(mbox_wr_ready),
        .event_status(event_status), .list_stall_status(list_stall_status), .event_mask(event_mask), .irq(irq));
    imc_host_model imc_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    //----------------------------------------------------------------
    // Clock, reset and watchdog
    //----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    //----------------------------------------------------------------
    // Helpers
    //----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        imc_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rdv, erv);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        imc_host_model_inst.xfer(1'b1, a, d, rdv, erv);
    endtask
    // Let n edges pass, then look once their updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // Accelerator write: hold valid and data until ready is seen high
    task automatic acc(input logic [31:0] w);
        @(posedge pclk);
        mbox_wr_valid <= 1'b1;
        mbox_wr_data <= w;
        @(posedge pclk);
        while (mbox_wr_ready !== 1'b1) @(posedge pclk);
        mbox_wr_valid <= 1'b0;
        mbox_wr_data <= ~w;
    endtask
    task automatic note(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic close_out;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Expected channel data; narrow channels read zero-extended
    function automatic logic [31:0] dat_exp(input logic [4:0] ch);
        case (ch)
            imc_pkg::CH_EVT_STAT: return {20'h0_0000, event_status};
            imc_pkg::CH_EVT_MASK: return {20'h0_0000, mexp};
            imc_pkg::CH_LIST: return list_stall_status;
            imc_pkg::CH_INTR_MBOX: return w1;
            default: return 32'h0000_0000;
        endcase
    endfunction
    // Slot is free here, so every reachable channel counts one
    function automatic logic [31:0] cnt_exp(input logic [4:0] ch);
        if (ch == imc_pkg::CH_DECR || ch == 5'h03) begin
            return 32'h0000_0000;
        end
        return 32'h0000_0001;
    endfunction

    //----------------------------------------------------------------
    // Main sequence
    //----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        mbox_wr_valid = 1'b0;
        mbox_wr_data = 32'h0000_0000;
        event_status = 12'h000;
        list_stall_status = 32'h0000_0000;
        mexp = 12'h000;
        void'($urandom(32'hB424));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk("ready", mbox_wr_ready, 32'h1);
        chk("irq", irq, 32'h0);
        chk("evmask", event_mask, 32'h0);
        rd(imc_pkg::OFS_INFO);
        chk("info", rdv, 32'h0000_0001);
        note("reset");
        // Full slot: second write stalls and must not overwrite
        wr(imc_pkg::OFS_MASK, 32'h0000_0001);
        w1 = $urandom;
        w2 = $urandom;
        acc(w1);
        tick(1);
        chk("ready", mbox_wr_ready, 32'h0);
        chk("irq", irq, 32'h1);
        fork
            acc(w2);
            begin
                tick(3);
                rd(imc_pkg::OFS_STAT);
                chk("stat", rdv, 32'h0000_0003);
                rd(imc_pkg::OFS_MBOX);
                chk("mbox", rdv, w1);
            end
        join
        tick(1);
        chk("ready", mbox_wr_ready, 32'h0);
        rd(imc_pkg::OFS_MBOX);
        chk("mbox", rdv, w2);
        tick(1);
        chk("ready", mbox_wr_ready, 32'h1);
        chk("irq", irq, 32'h0);
        rd(imc_pkg::OFS_MBOX);
        chk("mbox", rdv, w2);
        rd(imc_pkg::OFS_INFO);
        chk("info", rdv, 32'h0000_0001);
        wr(imc_pkg::OFS_STAT, 32'h0000_0003);
        rd(imc_pkg::OFS_STAT);
        chk("stat", rdv, 32'h0);
        note("mailbox");
        // Masked interrupt stays quiet until enabled
        wr(imc_pkg::OFS_MASK, 32'h0);
        acc(w1);
        tick(1);
        chk("irq", irq, 32'h0);
        rd(imc_pkg::OFS_STAT);
        chk("stat", rdv, 32'h0000_0001);
        wr(imc_pkg::OFS_MASK, 32'h0000_0001);
        tick(1);
        chk("irq", irq, 32'h1);
        // Software reinit of the count
        wr(imc_pkg::OFS_CTRL, 32'h0000_0002);
        tick(1);
        chk("ready", mbox_wr_ready, 32'h1);
        chk("irq", irq, 32'h0);
        rd(imc_pkg::OFS_MBOX);
        chk("mbox", rdv, w1);
        note("mask_reinit");
        // Channel select table
        for (int i = 0; i < 6; i++) begin
            c = tbl[i];
            wd = $urandom;
            @(posedge pclk);
            event_status <= 12'($urandom);
            list_stall_status <= $urandom;
            wr(imc_pkg::OFS_SEL, {27'h0, c});
            rd(imc_pkg::OFS_SEL);
            chk("sel", rdv, {27'h0, c});
            wr(imc_pkg::OFS_DATA, wd);
            if (c == imc_pkg::CH_EVT_MASK) begin
                mexp = wd[11:0];
            end
            rd(imc_pkg::OFS_CNT);
            chk("cnt", rdv, cnt_exp(c));
            rd(imc_pkg::OFS_DATA);
            chk("data", rdv, dat_exp(c));
            chk("evmask", event_mask, {20'h0, mexp});
        end
        note("channels");
        // Isolation pins the select on the decrementer
        wr(imc_pkg::OFS_CTRL, 32'h0000_0001);
        wr(imc_pkg::OFS_SEL, {27'h0, imc_pkg::CH_EVT_MASK});
        rd(imc_pkg::OFS_SEL);
        chk("sel", rdv, {27'h0, imc_pkg::CH_DECR});
        wr(imc_pkg::OFS_DATA, $urandom);
        rd(imc_pkg::OFS_CNT);
        chk("cnt", rdv, 32'h0);
        rd(imc_pkg::OFS_DATA);
        chk("data", rdv, 32'h0);
        chk("evmask", event_mask, {20'h0, mexp});
        wr(imc_pkg::OFS_CTRL, 32'h0);
        note("isolation");
        // Unmapped place: error, zero data, no side effect
        rd(8'h20);
        chk("err", erv, 32'h1);
        chk("data", rdv, 32'h0);
        wr(8'h14 + 8'h10, 32'hFFFF_FFFF);
        chk("err", erv, 32'h1);
        rd(imc_pkg::OFS_MASK);
        chk("mask", rdv, 32'h0000_0001);
        note("unmapped");
        // Random words stream through the one-deep slot
        repeat (20) begin
            wd = $urandom;
            acc(wd);
            rd(imc_pkg::OFS_MBOX);
            chk("mbox", rdv, wd);
            chk("err", erv, 32'h0);
            chk("waits", imc_host_model_inst.waits, 32'h0);
        end
        note("stream");
        close_out();
    end
endmodule
